/* hw/bcr_regs.svh */
// Register indices, field positions, reset values and timing figures of the control bank
//
// Notes on behaviour
// - Board-type identifier is 16 bits, read-only, upper and lower bytes at two addresses.
// - Revision byte: board revision in upper nibble, logic revision in lower nibble.
// - Slot address is five read-only bits; upper three bits read zero.
// - Slot address returns to default only on power-on reset, never on warm reset.
// - Watchdog counts a timeout chosen by a four-bit period field, 125 ms to 4096 s.
// - Watchdog is disarmed after power-on and stays idle until the arm bit is set.
// - Once armed, disarm and mode changes are ignored; arm bit reads one until power cycle.
// - Writing one to arm/kick while armed restarts the timeout period.
// - Each timeout sets the expiry flag; writing one clears it, zero leaves it.
// - Expiry flag survives warm and watchdog resets; cleared by power cycle or software.
// - Two-bit mode selects flag only, hard reset, interrupt or dual-stage.
// - Flag-only timeout just sets the flag; resume by clearing flag then kicking.
// - Reset mode timeout asserts a hard system reset.
// - Interrupt mode timeout raises an interrupt, routed by the routing field.
// - Dual-stage first timeout raises interrupt and restarts with same period.
// - Dual-stage second timeout with no kick between asserts a hard reset.
// - LED function field: zero shows boot progress, one software control, rest reserved.
// - Boot progress shows upper nibble, lower nibble, then pause, in green, repeating.
// - Until the first progress code write, LEDs show red fault indications.
// - Command nibble: get LED 0-3 is 0-3, set LED 0-3 is 8-11; resets zero.
// - Colour nibble: off 0, green 1, red 2, red and green 3; resets zero.
// - General output bits drive rear outputs; reset zero; upper four bits read zero.
// - Watchdog interrupt delivered only when routing field selects line one; zero suppresses.
`ifndef BCR_REGS_SVH
`define BCR_REGS_SVH

// Register indices; byte address is four times the index
`define BCR_IDX_ROUTE     10'h286
`define BCR_IDX_ID_HI     10'h288
`define BCR_IDX_REV       10'h289
`define BCR_IDX_SLOT      10'h28A
`define BCR_IDX_WD        10'h28C
`define BCR_IDX_ID_LO     10'h28D
`define BCR_IDX_LED_CFG   10'h290
`define BCR_IDX_LED_CMD   10'h291
`define BCR_IDX_GPO       10'h292
`define BCR_IDX_POST      10'h2A0

// Watchdog control fields
`define BCR_WD_EXP_BIT    7
`define BCR_WD_MODE_HI    6
`define BCR_WD_MODE_LO    5
`define BCR_WD_ARM_BIT    4
`define BCR_WD_PER_HI     3
`define BCR_WD_PER_LO     0
`define BCR_WD_MODE_FLAG  2'h0
`define BCR_WD_MODE_RST   2'h1
`define BCR_WD_MODE_IRQ   2'h2
`define BCR_WD_MODE_DUAL  2'h3
`define BCR_ROUTE_LINE    2'h1

// LED command and function encodings
`define BCR_LED_FN_POST   4'h0
`define BCR_LED_FN_SOFT   4'h1
`define BCR_LED_CMD_SET   1'h1
`define BCR_LED_CMD_RSV   1'h0
`define BCR_COL_MAX       4'h3

// Reset values
`define BCR_RST_BYTE      8'h00
`define BCR_RST_NIB       4'h0

// Timing: base watchdog tick and LED display phase
`define BCR_CLK_MHZ       250
`define BCR_WD_BASE_MS    125
`define BCR_LED_PHASE_MS  500
`define BCR_WD_TICK_CYC   (`BCR_WD_BASE_MS * `BCR_CLK_MHZ * 1000)
`define BCR_LED_PHASE_CYC (`BCR_LED_PHASE_MS * `BCR_CLK_MHZ * 1000)

`endif

/* hw/bcr_pkg.sv */
// Types shared by the board control register bank
package bcr_pkg;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_ROUTE, SEL_ID_HI, SEL_REV, SEL_SLOT, SEL_WD,
    SEL_ID_LO, SEL_LED_CFG, SEL_LED_CMD, SEL_GPO, SEL_POST
  } bcr_sel_e;

  typedef enum logic [1:0] {
    PH_HIGH, PH_LOW, PH_PAUSE
  } bcr_phase_e;

  typedef struct packed {
    logic [3:0] red;
    logic [3:0] green;
  } bcr_lamp_s;

  typedef struct packed {
    logic power_good_missing;
    logic cpu_fatal;
    logic pci_reset_stuck;
    logic boot_failed;
  } bcr_fault_s;

endpackage : bcr_pkg

/* hw/bcr_top.sv */
// Board control register bank: identity, slot, watchdog, debug lamps, rear outputs
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "bcr_regs.svh"

module bcr_top #(
  parameter logic [15:0] BOARD_ID     = 16'h5A00,   // Arbitrary neutral identifier
  parameter logic [3:0]  BOARD_REV    = 4'h0,
  parameter logic [3:0]  LOGIC_REV    = 4'h0,
  parameter int unsigned WD_TICK_CYC  = `BCR_WD_TICK_CYC,
  parameter int unsigned LED_PHASE_CYC = `BCR_LED_PHASE_CYC
) (
  input  wire  logic               mclk,          // 250 MHz clock
  input  wire  logic               nrst,          // Power-on reset, async
  input  wire  logic               warm_rst_n,    // Warm reset, sync
  input  wire  logic               psel,          // APB select
  input  wire  logic               penable,       // APB enable
  input  wire  logic               pwrite,        // APB direction
  input  wire  logic [11:0]        paddr,         // APB byte address
  input  wire  logic [31:0]        pwdata,        // APB write data
  output logic       [31:0]        prdata,        // APB read data
  output logic                     pready,        // APB ready
  output logic                     pslverr,       // APB error
  input  wire  logic [4:0]         site_number,   // Backplane slot address
  input  wire  bcr_pkg::bcr_fault_s fault_in,     // Power-up fault indications
  output bcr_pkg::bcr_lamp_s       debug_lamp,    // Debug lamp drive
  output logic [3:0]               general_out,   // Rear general outputs
  output logic                     wd_irq,        // Watchdog interrupt request
  output logic                     wd_hard_reset  // Watchdog hard reset pulse
);

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic bcr_pkg::bcr_sel_e reg_sel(input logic [11:0] a);
    logic [9:0] idx;
    idx = a[11:2];
    if (a[1:0] != 2'h0)                reg_sel = bcr_pkg::SEL_NONE;
    else if (idx == `BCR_IDX_ROUTE)    reg_sel = bcr_pkg::SEL_ROUTE;
    else if (idx == `BCR_IDX_ID_HI)    reg_sel = bcr_pkg::SEL_ID_HI;
    else if (idx == `BCR_IDX_REV)      reg_sel = bcr_pkg::SEL_REV;
    else if (idx == `BCR_IDX_SLOT)     reg_sel = bcr_pkg::SEL_SLOT;
    else if (idx == `BCR_IDX_WD)       reg_sel = bcr_pkg::SEL_WD;
    else if (idx == `BCR_IDX_ID_LO)    reg_sel = bcr_pkg::SEL_ID_LO;
    else if (idx == `BCR_IDX_LED_CFG)  reg_sel = bcr_pkg::SEL_LED_CFG;
    else if (idx == `BCR_IDX_LED_CMD)  reg_sel = bcr_pkg::SEL_LED_CMD;
    else if (idx == `BCR_IDX_GPO)      reg_sel = bcr_pkg::SEL_GPO;
    else if (idx == `BCR_IDX_POST)     reg_sel = bcr_pkg::SEL_POST;
    else                               reg_sel = bcr_pkg::SEL_NONE;
  endfunction : reg_sel

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [31:0]          prdata_reg,    prdata_next;
  logic                 pready_reg,    pready_next;
  logic                 pslverr_reg,   pslverr_next;
  logic [4:0]           slot_reg,      slot_next;
  logic                 slot_ok_reg,   slot_ok_next;
  logic                 armed_reg,     armed_next;
  logic                 run_reg,       run_next;
  logic                 exp_reg,       exp_next;
  logic [1:0]           mode_reg,      mode_next;
  logic [3:0]           period_reg,    period_next;
  logic                 stage_reg,     stage_next;
  logic [31:0]          tick_reg,      tick_next;
  logic [15:0]          pcnt_reg,      pcnt_next;
  logic                 irq_reg,       irq_next;
  logic                 hrst_reg,      hrst_next;
  logic [1:0]           route_reg,     route_next;
  logic [3:0]           led_fn_reg,    led_fn_next;
  logic [3:0]           led_cmd_reg,   led_cmd_next;
  logic [3:0]           led_col_reg,   led_col_next;
  logic [1:0]           soft_col_reg [4];
  logic [1:0]           soft_col_next[4];
  logic [7:0]           post_reg,      post_next;
  logic                 post_seen_reg, post_seen_next;
  bcr_pkg::bcr_phase_e  phase_reg,     phase_next;
  logic [31:0]          phcnt_reg,     phcnt_next;
  bcr_pkg::bcr_lamp_s   lamp_reg,      lamp_next;
  logic [3:0]           gpo_reg,       gpo_next;

  bcr_pkg::bcr_sel_e    sel;
  logic                 wr_commit;
  logic                 setup;
  logic                 timeout;
  logic [15:0]          pcnt_last;
  logic [3:0]           fault_vec;

  assign sel       = reg_sel(paddr);
  assign setup     = psel & ~penable;
  assign wr_commit = psel & penable & pready_reg & pwrite;
  assign pcnt_last = (16'h1 << period_reg) - 16'h1;
  assign timeout   = armed_reg & run_reg & (tick_reg == WD_TICK_CYC - 1)
                   & (pcnt_reg == pcnt_last);
  assign fault_vec = {fault_in.power_good_missing, fault_in.cpu_fatal,
                      fault_in.pci_reset_stuck, fault_in.boot_failed};

  // ------------------------------------------------------------
  // APB slave: read data sampled in setup, answer in first access cycle
  // ------------------------------------------------------------
  always_comb begin
    prdata_next  = prdata_reg;
    pready_next  = setup;
    pslverr_next = 1'b0;
    if (setup) begin
      prdata_next = 32'h0;
      case (sel)
        bcr_pkg::SEL_ROUTE:   prdata_next[1:0] = route_reg;
        bcr_pkg::SEL_ID_HI:   prdata_next[7:0] = BOARD_ID[15:8];
        bcr_pkg::SEL_ID_LO:   prdata_next[7:0] = BOARD_ID[7:0];
        bcr_pkg::SEL_REV:     prdata_next[7:0] = {BOARD_REV, LOGIC_REV};
        bcr_pkg::SEL_SLOT:    prdata_next[7:0] = {3'h0, slot_reg};
        bcr_pkg::SEL_WD:      prdata_next[7:0] = {exp_reg, mode_reg,
                                                  armed_reg, period_reg};
        bcr_pkg::SEL_LED_CFG: prdata_next[7:0] = {4'h0, led_fn_reg};
        bcr_pkg::SEL_LED_CMD: prdata_next[7:0] = {led_cmd_reg, led_col_reg};
        bcr_pkg::SEL_GPO:     prdata_next[7:0] = {4'h0, gpo_reg};
        bcr_pkg::SEL_POST:    prdata_next[7:0] = post_reg;
        default:              pslverr_next     = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ------------------------------------------------------------
  // Slot address: caught once after power-on release, kept over warm reset
  // ------------------------------------------------------------
  always_comb begin
    slot_next    = slot_reg;
    slot_ok_next = 1'b1;
    if (!slot_ok_reg) begin
      slot_next = site_number;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      slot_reg    <= 5'h0;
      slot_ok_reg <= 1'b0;
    end else begin
      slot_reg    <= slot_next;
      slot_ok_reg <= slot_ok_next;
    end
  end

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  // Only power-on reset touches this group; warm reset leaves the lock and flag.
  always_comb begin
    logic wd_wr;
    logic kick;
    logic irq_hit;
    wd_wr       = wr_commit & (sel == bcr_pkg::SEL_WD);
    kick        = wd_wr & armed_reg & pwdata[`BCR_WD_ARM_BIT];
    irq_hit     = 1'b0;
    armed_next  = armed_reg;
    run_next    = run_reg;
    exp_next    = exp_reg;
    mode_next   = mode_reg;
    period_next = period_reg;
    stage_next  = stage_reg;
    irq_next    = irq_reg;
    hrst_next   = 1'b0;
    tick_next   = tick_reg;
    pcnt_next   = pcnt_reg;
    if (armed_reg && run_reg) begin
      if (tick_reg == WD_TICK_CYC - 1) begin
        tick_next = 32'h0;
        pcnt_next = pcnt_reg + 16'h1;
      end else begin
        tick_next = tick_reg + 32'h1;
      end
    end
    if (wd_wr && pwdata[`BCR_WD_EXP_BIT]) begin
      exp_next = 1'b0;
      irq_next = 1'b0;
    end
    if (wd_wr && !armed_reg) begin
      mode_next   = pwdata[`BCR_WD_MODE_HI:`BCR_WD_MODE_LO];
      period_next = pwdata[`BCR_WD_PER_HI:`BCR_WD_PER_LO];
      if (pwdata[`BCR_WD_ARM_BIT]) begin
        armed_next = 1'b1;
        run_next   = 1'b1;
        tick_next  = 32'h0;
        pcnt_next  = 16'h0;
      end
    end
    if (timeout) begin
      exp_next  = 1'b1;
      tick_next = 32'h0;
      pcnt_next = 16'h0;
      case (mode_reg)
        `BCR_WD_MODE_FLAG: run_next  = 1'b0;
        `BCR_WD_MODE_RST:  hrst_next = 1'b1;
        `BCR_WD_MODE_IRQ:  irq_hit   = 1'b1;
        default: begin
          if (stage_reg) begin
            hrst_next  = 1'b1;
            stage_next = 1'b0;
          end else begin
            irq_hit    = 1'b1;
            stage_next = 1'b1;
          end
        end
      endcase
    end
    if (kick) begin
      tick_next  = 32'h0;
      pcnt_next  = 16'h0;
      stage_next = 1'b0;
      irq_next   = 1'b0;
      if (mode_reg != `BCR_WD_MODE_FLAG || !exp_next) begin
        run_next = 1'b1;
      end
    end
    if (irq_hit && route_reg == `BCR_ROUTE_LINE) begin
      irq_next = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      armed_reg  <= 1'b0;
      run_reg    <= 1'b0;
      exp_reg    <= 1'b0;
      mode_reg   <= `BCR_WD_MODE_FLAG;
      period_reg <= `BCR_RST_NIB;
      stage_reg  <= 1'b0;
      irq_reg    <= 1'b0;
      hrst_reg   <= 1'b0;
      tick_reg   <= 32'h0;
      pcnt_reg   <= 16'h0;
    end else begin
      armed_reg  <= armed_next;
      run_reg    <= run_next;
      exp_reg    <= exp_next;
      mode_reg   <= mode_next;
      period_reg <= period_next;
      stage_reg  <= stage_next;
      irq_reg    <= irq_next;
      hrst_reg   <= hrst_next;
      tick_reg   <= tick_next;
      pcnt_reg   <= pcnt_next;
    end
  end

  // ------------------------------------------------------------
  // Software-written control: routing, lamps, progress code, outputs
  // ------------------------------------------------------------
  always_comb begin
    route_next     = route_reg;
    led_fn_next    = led_fn_reg;
    led_cmd_next   = led_cmd_reg;
    led_col_next   = led_col_reg;
    soft_col_next  = soft_col_reg;
    post_next      = post_reg;
    post_seen_next = post_seen_reg;
    gpo_next       = gpo_reg;
    if (!warm_rst_n) begin
      route_next     = 2'h0;
      led_fn_next    = `BCR_LED_FN_POST;
      led_cmd_next   = `BCR_RST_NIB;
      led_col_next   = `BCR_RST_NIB;
      soft_col_next  = '{default: 2'h0};
      post_next      = `BCR_RST_BYTE;
      post_seen_next = 1'b0;
      gpo_next       = `BCR_RST_NIB;
    end else if (wr_commit) begin
      case (sel)
        bcr_pkg::SEL_ROUTE:   route_next  = pwdata[1:0];
        bcr_pkg::SEL_LED_CFG: led_fn_next = pwdata[3:0];
        bcr_pkg::SEL_GPO:     gpo_next    = pwdata[3:0];
        bcr_pkg::SEL_POST: begin
          post_next      = pwdata[7:0];
          post_seen_next = 1'b1;
        end
        bcr_pkg::SEL_LED_CMD: begin
          led_cmd_next = pwdata[7:4];
          led_col_next = pwdata[3:0];
          if (led_fn_reg == `BCR_LED_FN_SOFT && pwdata[6] == 1'b0) begin
            if (pwdata[7] == `BCR_LED_CMD_SET) begin
              if (pwdata[3:0] <= `BCR_COL_MAX) begin
                soft_col_next[pwdata[5:4]] = pwdata[1:0];
              end
            end else begin
              led_col_next = {2'h0, soft_col_reg[pwdata[5:4]]};
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      route_reg     <= 2'h0;
      led_fn_reg    <= `BCR_LED_FN_POST;
      led_cmd_reg   <= `BCR_RST_NIB;
      led_col_reg   <= `BCR_RST_NIB;
      soft_col_reg  <= '{default: 2'h0};
      post_reg      <= `BCR_RST_BYTE;
      post_seen_reg <= 1'b0;
      gpo_reg       <= `BCR_RST_NIB;
    end else begin
      route_reg     <= route_next;
      led_fn_reg    <= led_fn_next;
      led_cmd_reg   <= led_cmd_next;
      led_col_reg   <= led_col_next;
      soft_col_reg  <= soft_col_next;
      post_reg      <= post_next;
      post_seen_reg <= post_seen_next;
      gpo_reg       <= gpo_next;
    end
  end

  // ------------------------------------------------------------
  // Progress display sequencer
  // ------------------------------------------------------------
  always_comb begin
    phase_next = phase_reg;
    phcnt_next = phcnt_reg + 32'h1;
    if (phcnt_reg == LED_PHASE_CYC - 1) begin
      phcnt_next = 32'h0;
      case (phase_reg)
        bcr_pkg::PH_HIGH: phase_next = bcr_pkg::PH_LOW;
        bcr_pkg::PH_LOW:  phase_next = bcr_pkg::PH_PAUSE;
        default:          phase_next = bcr_pkg::PH_HIGH;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= bcr_pkg::PH_HIGH;
      phcnt_reg <= 32'h0;
    end else begin
      phase_reg <= phase_next;
      phcnt_reg <= phcnt_next;
    end
  end

  // ------------------------------------------------------------
  // Per-lamp colour choice
  // ------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_lamp
    always_comb begin
      lamp_next.red[i]   = 1'b0;
      lamp_next.green[i] = 1'b0;
      if (!post_seen_reg) begin
        lamp_next.red[i] = fault_vec[i];
      end else if (led_fn_reg == `BCR_LED_FN_POST) begin
        if (phase_reg == bcr_pkg::PH_HIGH) begin
          lamp_next.green[i] = post_reg[i + 4];
        end else if (phase_reg == bcr_pkg::PH_LOW) begin
          lamp_next.green[i] = post_reg[i];
        end
      end else if (led_fn_reg == `BCR_LED_FN_SOFT) begin
        lamp_next.red[i]   = soft_col_reg[i][1];
        lamp_next.green[i] = soft_col_reg[i][0];
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lamp_reg <= '0;
    end else begin
      lamp_reg <= lamp_next;
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign debug_lamp    = lamp_reg;
  assign general_out   = gpo_reg;
  assign wd_irq        = irq_reg;
  assign wd_hard_reset = hrst_reg;

endmodule : bcr_top

/* tb/bcr_chk.sv */
// Assertion checker for the board control register bank
`timescale 1ns/1ps
`include "bcr_regs.svh"
module bcr_chk #(
  parameter logic [15:0] BOARD_ID  = 16'h1234, // Arbitrary value
  parameter logic [3:0]  BOARD_REV = 4'h0,
  parameter logic [3:0]  LOGIC_REV = 4'h0
) (
  input wire logic        mclk,         // Clock
  input wire logic        nrst,         // Reset
  input wire logic        psel,         // Select
  input wire logic        penable,      // Enable
  input wire logic        pwrite,       // Direction
  input wire logic [11:0] paddr,        // Address
  input wire logic [31:0] pwdata,       // Write data
  input wire logic [31:0] prdata,       // Read data
  input wire logic        pready,       // Ready
  input wire logic        pslverr,      // Error
  input wire logic [4:0]  site_number,  // Slot
  input wire logic [3:0]  general_out,  // Outputs
  input wire logic        wd_hard_reset // Hard reset
);
  // ----------------------------------------
  // Bus and register relations
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic rd = pready && !pwrite && !pslverr;

  // Slot value as caught after power-on release; warm reset must not move it
  logic [4:0] slot_seen;
  logic       slot_cap;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      slot_cap  <= 1'b0;
      slot_seen <= 5'h0;
    end else if (!slot_cap) begin
      slot_cap  <= 1'b1;
      slot_seen <= site_number;
    end
  end

  AST_RDY: assert property (psel && !penable |=> pready) else $error("ready late");
  AST_IDLE: assert property (!psel |=> !pready && !pslverr) else $error("ready idle");
  AST_IDH: assert property (rd && paddr == {`BCR_IDX_ID_HI, 2'h0} |-> prdata == {24'h0, BOARD_ID[15:8]}) else $error("id hi");
  AST_IDL: assert property (rd && paddr == {`BCR_IDX_ID_LO, 2'h0} |-> prdata == {24'h0, BOARD_ID[7:0]}) else $error("id lo");
  AST_REV: assert property (rd && paddr == {`BCR_IDX_REV, 2'h0} |-> prdata[7:0] == {BOARD_REV, LOGIC_REV}) else $error("rev");
  AST_SLOT: assert property (rd && paddr == {`BCR_IDX_SLOT, 2'h0} |-> prdata == {27'h0, slot_seen}) else $error("slot");
  AST_GPO: assert property (pready && pwrite && paddr == {`BCR_IDX_GPO, 2'h0} |=> general_out == $past(pwdata[3:0])) else $error("gpo");
  AST_HRST: assert property (wd_hard_reset |=> !wd_hard_reset) else $error("reset pulse");
  AST_ERR: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0) else $error("error read");
endmodule : bcr_chk

bind bcr_top bcr_chk #(.BOARD_ID(BOARD_ID), .BOARD_REV(BOARD_REV), .LOGIC_REV(LOGIC_REV)) u_chk (
  .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .site_number(site_number), .general_out(general_out), .wd_hard_reset(wd_hard_reset));

/* tb/tb.sv */
// Self-checking bench for the board control register bank
`timescale 1ns/1ps
`include "bcr_regs.svh"
module tb;
  localparam logic [15:0] ID = 16'h3C96; // Arbitrary value
  logic                mclk = 1'b0, nrst = 1'b0, warm_rst_n = 1'b1;
  logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]         paddr = 12'h0;
  logic [31:0]         pwdata = 32'h0, prdata, r;
  logic [4:0]          site_number = 5'h0;
  bcr_pkg::bcr_fault_s fault_in = 4'h0;
  bcr_pkg::bcr_lamp_s  debug_lamp;
  logic [3:0]          general_out, c;
  logic [7:0]          d;
  logic                pready, pslverr, wd_irq, wd_hard_reset, e;
  int                  n_fail = 0, n_checks = 0, nhr = 0, h0 = 0;

  always #2 mclk = ~mclk;
  always @(posedge mclk) if (wd_hard_reset === 1'b1) nhr <= nhr + 1;

  bcr_top #(.BOARD_ID(ID), .BOARD_REV(4'h2), .LOGIC_REV(4'h5), .WD_TICK_CYC(4),
    .LED_PHASE_CYC(8)) uut (.mclk(mclk), .nrst(nrst), .warm_rst_n(warm_rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .site_number(site_number), .fault_in(fault_in),
    .debug_lamp(debug_lamp), .general_out(general_out), .wd_irq(wd_irq),
    .wd_hard_reset(wd_hard_reset));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, v};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_fail++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task automatic rd(input logic [9:0] idx, input logic [7:0] x);
    bus(1'b0, idx, 8'h0);
    chk(r, {24'h0, x});
  endtask : rd

  task automatic waitg(input logic [3:0] v);
    int k;
    k = 0;
    while (debug_lamp.green !== v && k < 40) begin
      @(posedge mclk);
      k++;
    end
    chk(debug_lamp.green, v);
  endtask : waitg

  task automatic por();
    nrst <= 1'b0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
  endtask : por

  function automatic logic [7:0] wdv(input logic x, input logic [1:0] m, input logic a);
    return {x, m, a, 4'h0};
  endfunction : wdv

  task automatic summarize();
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    summarize();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    r = $urandom(32'hEDF1531A);
    site_number <= 5'($urandom);
    fault_in <= 4'($urandom);
    por();
    repeat (3) @(posedge mclk);
    chk({24'h0, debug_lamp}, {24'h0, fault_in, 4'h0});
    rd(`BCR_IDX_ID_HI, ID[15:8]);
    rd(`BCR_IDX_ID_LO, ID[7:0]);
    rd(`BCR_IDX_REV, 8'h25);
    rd(`BCR_IDX_SLOT, {3'h0, site_number});
    rd(`BCR_IDX_WD, 8'h00);
    rd(`BCR_IDX_LED_CMD, 8'h00);
    bus(1'b1, `BCR_IDX_ID_HI, 8'hFF);
    rd(`BCR_IDX_ID_HI, ID[15:8]);
    bus(1'b0, 10'h3FF, 8'h0);
    chk(e, 1'b1);
    d = 8'($urandom);
    bus(1'b1, `BCR_IDX_GPO, d);
    rd(`BCR_IDX_GPO, {4'h0, d[3:0]});
    chk(general_out, d[3:0]);
    // First progress code arrives; then each lamp is set and read back under software control
    bus(1'b1, `BCR_IDX_POST, 8'hC3);
    bus(1'b1, `BCR_IDX_LED_CFG, 8'h01);
    for (int i = 0; i < 4; i++) begin
      c = 4'($urandom % 4);
      bus(1'b1, `BCR_IDX_LED_CMD, {2'h2, i[1:0], c});
      bus(1'b1, `BCR_IDX_LED_CMD, {2'h0, i[1:0], 4'h0});
      rd(`BCR_IDX_LED_CMD, {2'h0, i[1:0], c});
      chk({debug_lamp.red[i], debug_lamp.green[i]}, c[1:0]);
    end
    bus(1'b1, `BCR_IDX_LED_CFG, 8'h00);
    waitg(4'hC);
    waitg(4'h3);
    waitg(4'h0);
    chk(debug_lamp.red, 4'h0);
    bus(1'b1, `BCR_IDX_WD, 8'h10);
    repeat (20) @(posedge mclk);
    rd(`BCR_IDX_WD, wdv(1'b1, 2'h0, 1'b1));
    bus(1'b1, `BCR_IDX_WD, 8'h60);
    rd(`BCR_IDX_WD, wdv(1'b1, 2'h0, 1'b1));
    bus(1'b1, `BCR_IDX_WD, 8'h80);
    repeat (20) @(posedge mclk);
    rd(`BCR_IDX_WD, wdv(1'b0, 2'h0, 1'b1));
    bus(1'b1, `BCR_IDX_WD, 8'h90);
    repeat (20) @(posedge mclk);
    rd(`BCR_IDX_WD, wdv(1'b1, 2'h0, 1'b1));
    d = {3'h0, site_number};
    site_number <= ~site_number;
    warm_rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    warm_rst_n <= 1'b1;
    rd(`BCR_IDX_SLOT, d);
    rd(`BCR_IDX_WD, wdv(1'b1, 2'h0, 1'b1));
    chk(general_out, 4'h0);
    // Mode 4 stands for interrupt mode with routing off
    for (int m = 1; m < 5; m++) begin
      site_number <= 5'($urandom);
      por();
      bus(1'b1, `BCR_IDX_ROUTE, {7'h0, m != 4});
      h0 = nhr;
      bus(1'b1, `BCR_IDX_WD, wdv(1'b0, (m == 4) ? 2'h2 : m[1:0], 1'b1));
      repeat (20) @(posedge mclk);
      chk(nhr != h0, m == 1 || m == 3);
      chk(wd_irq, m == 2 || m == 3);
      rd(`BCR_IDX_SLOT, {3'h0, site_number});
    end
    summarize();
  end
endmodule : tb
